// *** flash_support.sv ***
// Purpose: Flash timing clock select/divide, per-row stress budget, marginal read
// Assumes: CPU drives a plain register port; clock sources are pin-level inputs
// Notes: Functional notes
// Functional notes
// - Timing generator source is auxiliary, subsystem or main clock.
// - Source select field picks clock; divide field picks division ratio.
// - Programming stresses whole 64-byte row; accumulated high-voltage time limited; code only flags a count above limit_q, never blocks.
// - Erasing a row clears its accumulated programming time.
// - Marginal read enable selects stricter sensing margin for reads.
// - Supply change flag in control register tracks supply shifts during programming.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module flash_support
  import flash_support_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register port
  input wire logic [flash_support_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flash_support_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [flash_support_pkg::DATA_W-1:0] reg_rdata,
  // Clock sources from pins
  input wire logic aux_clock,
  input wire logic subsystem_clock,
  input wire logic main_clock,
  // Supply monitor comparator from pin
  input wire logic supply_level,
  // Flash array controls
  output logic high_voltage,
  output logic margin_read,
  output logic [flash_support_pkg::ROW_W-1:0] hv_row,
  // Interrupt
  output logic irq
);
  import flash_support_pkg::*;

  // Two-stage synchronisers for all pin inputs
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else if (clk_en)
    begin
      sync1_q <= {supply_level, main_clock, subsystem_clock, aux_clock};
      sync2_q <= sync1_q;
    end
  end

  // Control register
  logic [SEL_W-1:0] clock_source_select;
  logic [DIV_W-1:0] clock_divide_ratio;
  logic margin_q;
  logic [CNT_W-1:0] limit_q;
  logic [ROW_W-1:0] row_q;
  logic [IRQ_N-1:0] irq_stat_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic supply_change_flag;
  op_t op_q;
  logic [CNT_W-1:0] op_cnt_q;
  logic [CNT_W-1:0] stress_q [ROWS];
  logic [ROWS-1:0] viol_q;
  logic ftg_tick;
  logic wr_cmd;
  assign wr_cmd = clk_en && reg_wr && (reg_addr == REG_CMD) && (op_q == ST_IDLE);

  // Software settings; divider changes take effect on the next source edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_source_select <= SRC_AUX;
      clock_divide_ratio <= '0;
      margin_q <= 1'b0;
      limit_q <= LIMIT_RST;
      row_q <= '0;
      irq_en_q <= '0;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          clock_source_select <= reg_wdata[CTRL_SEL_LO +: SEL_W];
          clock_divide_ratio <= reg_wdata[CTRL_DIV_LO +: DIV_W];
          margin_q <= reg_wdata[CTRL_MARGIN];
        end
        REG_LIMIT: limit_q <= reg_wdata[CNT_W-1:0];
        REG_ROW: row_q <= reg_wdata[ROW_W-1:0];
        REG_IRQ_EN: irq_en_q <= reg_wdata[IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  // Marginal read drives the sense amplifiers directly
  assign margin_read = margin_q;

  // Source mux and edge detect; the reserved code falls back to the main clock
  logic src_lvl;
  logic src_prev_q;
  always_comb
  begin
    case (clock_source_select)
      SRC_AUX: src_lvl = sync2_q[0];
      SRC_SUB: src_lvl = sync2_q[1];
      default: src_lvl = sync2_q[2];
    endcase
  end

  // Divider: one timing tick per (ratio+1) source rising edges
  logic [DIV_W-1:0] div_cnt_q;
  logic src_rise;
  assign src_rise = src_lvl && !src_prev_q;
  assign ftg_tick = clk_en && src_rise && (div_cnt_q == clock_divide_ratio);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_prev_q <= 1'b0;
      div_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      src_prev_q <= src_lvl;
      if (src_rise)
        div_cnt_q <= (div_cnt_q >= clock_divide_ratio) ? '0 : div_cnt_q + 1'b1;
    end
  end

  // Operation sequencer: timing ticks measure the high-voltage pulse
  logic op_end;
  assign op_end = ftg_tick && (op_q != ST_IDLE) &&
                  (op_cnt_q == ((op_q == ST_PROG) ? PROG_TICKS : ERASE_TICKS) - 16'h0001);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_q <= ST_IDLE;
      op_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      case (op_q)
        ST_IDLE:
          if (wr_cmd && reg_wdata[CMD_ERASE])
          begin
            op_q <= ST_ERASE;
            op_cnt_q <= '0;
          end
          else if (wr_cmd && reg_wdata[CMD_PROG])
          begin
            op_q <= ST_PROG;
            op_cnt_q <= '0;
          end
        ST_PROG, ST_ERASE:
          if (op_end)
            op_q <= ST_IDLE;
          else if (ftg_tick)
            op_cnt_q <= op_cnt_q + 16'h0001;
        default: op_q <= ST_IDLE;
      endcase
    end
  end

  // High voltage covers the entire selected row, whatever the write size
  assign high_voltage = (op_q != ST_IDLE);
  assign hv_row = row_q;

  // Per-row stress counters; saturate rather than wrap so a violation stays visible
  genvar r;
  generate
    for (r = 0; r < ROWS; r++)
    begin : g_row
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          stress_q[r] <= '0;
        else if (clk_en)
        begin
          if (op_q == ST_ERASE && op_end && row_q == ROW_W'(r))
            stress_q[r] <= '0;
          else if (op_q == ST_PROG && ftg_tick && row_q == ROW_W'(r) && stress_q[r] != '1)
            stress_q[r] <= stress_q[r] + 16'h0001;
        end
      end
      assign viol_q[r] = (stress_q[r] > limit_q);
    end
  endgenerate

  // Supply change flag follows the monitored supply level
  assign supply_change_flag = sync2_q[3];
  logic supply_start_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      supply_start_q <= 1'b0;
    else if (clk_en && wr_cmd)
      supply_start_q <= supply_change_flag;
  end

  // Sticky event bits; a new event wins over a same-cycle clear
  logic [IRQ_N-1:0] ev;
  logic viol_sel_prev_q;
  always_comb
  begin
    ev = '0;
    ev[IRQ_VIOL] = viol_q[row_q] && !viol_sel_prev_q;
    ev[IRQ_SUPPLY] = high_voltage && (supply_change_flag != supply_start_q);
    ev[IRQ_DONE] = op_end;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_stat_q <= '0;
      viol_sel_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      viol_sel_prev_q <= viol_q[row_q];
      if (reg_wr && reg_addr == REG_IRQ_CLR)
        irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_N-1:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // Read data stands the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          REG_CTRL: reg_rdata <= DATA_W'({supply_change_flag, margin_q, clock_divide_ratio, clock_source_select});
          REG_LIMIT: reg_rdata <= DATA_W'(limit_q);
          REG_ROW: reg_rdata <= DATA_W'(row_q);
          REG_STATUS: reg_rdata <= DATA_W'({viol_q[row_q], supply_change_flag, high_voltage});
          REG_IRQ_STAT: reg_rdata <= DATA_W'(irq_stat_q);
          REG_IRQ_EN: reg_rdata <= DATA_W'(irq_en_q);
          REG_COUNT: reg_rdata <= DATA_W'(stress_q[row_q]);
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // Stress grows by one on each programming tick of the selected row until it saturates
  property p_stress_grow;
    @(posedge clk) disable iff (!rstn)
    (clk_en && op_q == ST_PROG && ftg_tick && stress_q[row_q] != 16'hffff)
      |=> (stress_q[$past(row_q)] == $past(stress_q[row_q]) + 16'h0001);
  endproperty
  a_stress_grow: assert property (p_stress_grow) else $error("Row stress did not grow");

  property p_erase_clear;
    @(posedge clk) disable iff (!rstn)
    (clk_en && op_q == ST_ERASE && op_end) |=> (stress_q[$past(row_q)] == 16'h0000);
  endproperty
  a_erase_clear: assert property (p_erase_clear) else $error("Erase left row stress");

  // A fresh violation on the selected row must reach the sticky status bit
  property p_viol;
    @(posedge clk) disable iff (!rstn)
    (clk_en && viol_q[row_q] && !viol_sel_prev_q) |=> irq_stat_q[IRQ_VIOL];
  endproperty
  a_viol: assert property (p_viol) else $error("Violation event not latched");

  property p_margin;
    @(posedge clk) disable iff (!rstn)
    (clk_en && reg_wr && reg_addr == REG_CTRL) |=> (margin_read == $past(reg_wdata[CTRL_MARGIN]));
  endproperty
  a_margin: assert property (p_margin) else $error("Margin read not applied");

  property p_tick_div;
    @(posedge clk) disable iff (!rstn)
    ftg_tick |=> (div_cnt_q == '0);
  endproperty
  a_tick_div: assert property (p_tick_div) else $error("Divider did not wrap on tick");

  property p_src;
    @(posedge clk) disable iff (!rstn)
    ($stable(clock_source_select) && clock_source_select == SRC_SUB && sync2_q[1] && !$past(sync2_q[1]))
      |-> src_rise;
  endproperty
  a_src: assert property (p_src) else $error("Wrong source clock");

  property p_supply;
    @(posedge clk) disable iff (!rstn)
    ($past(clk_en) && $past(clk_en, 2) && supply_change_flag != $past(supply_change_flag))
      |-> (supply_change_flag == $past(supply_level, 2));
  endproperty
  a_supply: assert property (p_supply) else $error("Supply flag not synced");
endmodule
`default_nettype wire

// *** flash_support_pkg.sv ***
// Purpose: Shared constants for the flash support block
// Assumes: 10 MHz system clock, word-wide register port
// Notes: Register offsets are word indices on the plain register port
package flash_support_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LIMIT = 4'h1;
  localparam logic [3:0] REG_ROW = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_EN = 4'h6;
  localparam logic [3:0] REG_IRQ_CLR = 4'h7;
  localparam logic [3:0] REG_COUNT = 4'h8;
  // Control field layout
  localparam int CTRL_SEL_LO = 0;
  localparam int CTRL_DIV_LO = 2;
  localparam int CTRL_MARGIN = 8;
  localparam int SEL_W = 2;
  localparam int DIV_W = 6;
  // Clock source encodings
  localparam logic [1:0] SRC_AUX = 2'h0;
  localparam logic [1:0] SRC_SUB = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;
  // Command bits
  localparam int CMD_PROG = 0;
  localparam int CMD_ERASE = 1;
  // Rows: 64 bytes each
  localparam int ROW_BYTES = 64;
  localparam int ROWS = 16;
  localparam int ROW_W = 4;
  localparam int CNT_W = 16;
  localparam logic [15:0] LIMIT_RST = 16'h0400;
  // Interrupt bits
  localparam int IRQ_N = 3;
  localparam int IRQ_VIOL = 0;
  localparam int IRQ_SUPPLY = 1;
  localparam int IRQ_DONE = 2;
  // Pulse lengths in timing-generator ticks
  localparam logic [15:0] PROG_TICKS = 16'h0020;
  localparam logic [15:0] ERASE_TICKS = 16'h0100;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} op_t;
endpackage

// *** flash_support_bench.sv ***
// Purpose: Self-checking bench for the flash timing clock, row stress and margin logic
// Assumes: Slow source clocks are made here at fixed ratios of the system clock
// Notes: Pulse lengths are compared with a tolerance of one divided source period below and, for programming, one source period above
`timescale 1ns/1ns
`default_nettype none
module flash_support_bench;
  import flash_support_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic aux_clock = 1'b0;
  logic subsystem_clock = 1'b0;
  logic main_clock = 1'b0;
  logic supply_level = 1'b0;
  logic high_voltage;
  logic margin_read;
  logic [ROW_W-1:0] hv_row;
  logic irq;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed;
  int n;
  int tol;
  logic [31:0] v;
  logic [5:0] dv;
  logic [3:0] row;

  flash_support dut_u (.clk(clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_clock(aux_clock),
    .subsystem_clock(subsystem_clock), .main_clock(main_clock), .supply_level(supply_level),
    .high_voltage(high_voltage), .margin_read(margin_read), .hv_row(hv_row), .irq(irq));

  // System clock, 100 ns period
  always #50 clk = ~clk;

  // Sources toggle every 3, 5 and 7 cycles so each one has a distinct period
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    aux_clock <= 1'((cyc / 3) % 2);
    subsystem_clock <= 1'((cyc / 5) % 2);
    main_clock <= 1'((cyc / 7) % 2);
  end

  // Source period in system cycles; selects 2 and 3 both pick the main clock
  function automatic int per(input logic [1:0] s);
    case (s)
      2'h0: return 6;
      2'h1: return 10;
      default: return 14;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Returns just past the sampling edge so outputs launched there have settled
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data is only valid in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Waits for the pulse, checks its row, then counts its length under a bound
  task automatic hv_len(input logic [3:0] r, output int len);
    int w;
    w = 0;
    len = 0;
    while (high_voltage !== 1'b1 && w < 20)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    chk("hv_row", {28'h0, r}, {28'h0, hv_row});
    while (high_voltage === 1'b1 && len < 20000)
    begin
      @(posedge clk);
      #1;
      len++;
    end
  endtask

  task automatic stop_test;
    $display("Checks done %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of at most about 8000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    seed = 51768;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_LIMIT, v);
    chk("limit_reset", {16'h0, LIMIT_RST}, v);
    rd(4'hf, v);
    chk("unmapped", 32'h0, v);
    wr(REG_IRQ_EN, 32'h7);
    // Every source select with a random divide on its own row
    for (int s = 0; s < 4; s++)
    begin
      dv = 6'($unsigned($random(seed)) % 4);
      row = 4'(s * 4) + 4'($unsigned($random(seed)) % 4);
      wr(REG_CTRL, {24'h0, dv, 2'(s)});
      wr(REG_ROW, {28'h0, row});
      wr(REG_CMD, 32'h1);
      hv_len(row, n);
      tol = (32'(dv) + 1) * per(2'(s));
      chk("prog_len", 32'h1, {31'h0, (n > 32 * tol - tol - 5) && (n < 32 * tol + per(2'(s)) + 5)});
      rd(REG_COUNT, v);
      chk("row_count", 32'h20, v);
      chk("irq_done", 32'h1, {31'h0, irq});
      wr(REG_IRQ_CLR, 32'h7);
      chk("irq_clear", 32'h0, {31'h0, irq});
    end
    // Second program on the same row while busy must be ignored
    wr(REG_CTRL, 32'h0);
    wr(REG_LIMIT, 32'h46);
    wr(REG_CMD, 32'h1);
    wr(REG_CMD, 32'h1);
    hv_len(row, n);
    rd(REG_COUNT, v);
    chk("count_busy_cmd", 32'h40, v);
    rd(REG_STATUS, v);
    chk("no_viol", 32'h0, {31'h0, v[2]});
    wr(REG_CMD, 32'h1);
    hv_len(row, n);
    rd(REG_STATUS, v);
    chk("viol", 32'h1, {31'h0, v[2]});
    rd(REG_IRQ_STAT, v);
    chk("viol_irq", 32'h5, v);
    wr(REG_IRQ_EN, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_CLR, 32'h7);
    wr(REG_IRQ_EN, 32'h7);
    // Both strobes set means erase; it must clear the stress and the violation
    wr(REG_CMD, 32'h3);
    hv_len(row, n);
    chk("erase_len", 32'h1, {31'h0, (n > 256 * 6 - 11) && (n < 256 * 6 + 5)});
    rd(REG_COUNT, v);
    chk("erase_count", 32'h0, v);
    rd(REG_STATUS, v);
    chk("erase_viol", 32'h0, {31'h0, v[2]});
    wr(REG_IRQ_CLR, 32'h7);
    // Supply shift in mid-program must be flagged
    wr(REG_CMD, 32'h1);
    repeat (20) @(posedge clk);
    supply_level <= 1'b1;
    hv_len(row, n);
    rd(REG_IRQ_STAT, v);
    chk("supply_irq", 32'h1, {31'h0, v[1]});
    rd(REG_CTRL, v);
    chk("supply_flag", 32'h1, {31'h0, v[9]});
    // Marginal read mode on and off
    wr(REG_CTRL, 32'h100);
    chk("margin_on", 32'h1, {31'h0, margin_read});
    wr(REG_CTRL, 32'h0);
    chk("margin_off", 32'h0, {31'h0, margin_read});
    // Clock enable low freezes every register, so a control write is lost
    @(posedge clk);
    clk_en <= 1'b0;
    wr(REG_CTRL, 32'h100);
    chk("margin_frozen", 32'h0, {31'h0, margin_read});
    @(posedge clk);
    clk_en <= 1'b1;
    stop_test();
  end
endmodule
`default_nettype wire
